// [apmc_power_ctrl.v]
// Purpose: Power-mode sequencer of a parallel-bus converter
// Assumes: Strobes are synchronous to core_clk and active low
// Notes:   Power-up waits are timed by the host; ready flag is advisory
`timescale 1ns/1ps
`default_nettype none
`include "apmc_consts.vh"

module apmc_power_ctrl #(
    parameter         CTRL_WIDTH = 12,
    parameter         SHDN_CYC   = `APMC_SHDN_CYC,
    parameter         INT_REF    = 1
) (
    // Clock and reset
    input  wire                  core_clk,
    input  wire                  resetn,
    // Host bus
    input  wire                  cs_n,
    input  wire                  wr_n,
    input  wire [CTRL_WIDTH-1:0] wr_data,
    input  wire                  start_convert_n,
    // Status
    output reg                   busy_reg,
    output reg                   ref_on_reg,
    output reg                   core_on_reg,
    output reg                   track_reg,
    output reg                   powered_ready_reg,
    output reg  [CTRL_WIDTH-1:0] ctrl_reg_out
);

    localparam [3:0] ST_ON   = 4'b0001;
    localparam [3:0] ST_CONV = 4'b0010;
    localparam [3:0] ST_STBY = 4'b0100;
    localparam [3:0] ST_SHDN = 4'b1000;
    localparam [31:0] STBY_CYC = INT_REF ? `APMC_STBY_INT_CYC : `APMC_STBY_EXT_CYC;

    reg  [3:0]            state_reg;
    reg  [3:0]            state_next;
    reg  [1:0]            pin_d_reg;
    wire [1:0]            pin_now;
    reg  [7:0]            conv_cnt_reg;
    reg  [31:0]           wait_cnt_reg;
    wire [CTRL_WIDTH-1:0] ctrl_q;
    wire                  wr_rise;
    wire                  conv_rise;
    wire                  conv_fall;
    wire                  conv_done;
    wire [1:0]            pm;
    wire [1:0]            new_pm;

    assign pin_now   = {start_convert_n, wr_n};
    assign wr_rise   = !pin_d_reg[0] && wr_n && !cs_n;
    assign conv_rise = !pin_d_reg[1] && start_convert_n;
    assign conv_fall = pin_d_reg[1] && !start_convert_n;
    assign conv_done = state_reg == ST_CONV && conv_cnt_reg == `APMC_CONV_CYCLES;
    assign new_pm    = {wr_data[`APMC_PM_HIGH_POS], wr_data[`APMC_PM_LOW_POS]};
    assign pm        = wr_rise ? new_pm
                     : {ctrl_q[`APMC_PM_HIGH_POS], ctrl_q[`APMC_PM_LOW_POS]};

    // One decode for the mode-selecting writes in the state logic, except the pm case at conversion end
    function wr_sel;
        input       strobe;
        input [1:0] word_mode;
        input [1:0] mode;
        begin
            wr_sel = strobe && word_mode == mode;
        end
    endfunction

    // Both strobes idle high, so the delayed copies reset high: no false edge
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_edge
            always @(posedge core_clk) begin
                if (!resetn) begin
                    pin_d_reg[g] <= 1'b1;
                end else begin
                    pin_d_reg[g] <= pin_now[g];
                end
            end
        end
    endgenerate

    // Latching on the strobe rise keeps the write atomic with the mode change
    apmc_ctrl_mem #(
        .WIDTH   (CTRL_WIDTH)
    ) u_ctrl (
        .core_clk(core_clk),
        .resetn  (resetn),
        .wr_en   (wr_rise),
        .wr_data (wr_data),
        .rd_data (ctrl_q)
    );

    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_ON: begin
                if (wr_sel(wr_rise, new_pm, `APMC_PM_FULL_SHUTDOWN)) begin
                    state_next = ST_SHDN;
                end else if (conv_fall) begin
                    state_next = ST_CONV;
                end
            end
            ST_CONV: begin
                // A full shutdown write cuts a running conversion short
                if (wr_sel(wr_rise, new_pm, `APMC_PM_FULL_SHUTDOWN)) begin
                    state_next = ST_SHDN;
                end else if (conv_done) begin
                    case (pm)
                        `APMC_PM_AUTO_STANDBY:  state_next = ST_STBY;
                        `APMC_PM_AUTO_SHUTDOWN: state_next = ST_SHDN;
                        `APMC_PM_FULL_SHUTDOWN: state_next = ST_SHDN;
                        default:                state_next = ST_ON;
                    endcase
                end
            end
            ST_STBY: begin
                if (wr_sel(wr_rise, new_pm, `APMC_PM_FULL_SHUTDOWN)) begin
                    state_next = ST_SHDN;
                end else if (conv_rise || wr_sel(wr_rise, new_pm, `APMC_PM_NORMAL)) begin
                    state_next = ST_ON;
                end
            end
            ST_SHDN: begin
                // A write decides first; the start pin wakes only the automatic mode
                if (wr_sel(wr_rise, new_pm, `APMC_PM_NORMAL)) begin
                    state_next = ST_ON;
                end else if (wr_sel(wr_rise, new_pm, `APMC_PM_AUTO_STANDBY)) begin
                    state_next = ST_STBY;
                end else if (!wr_rise && pm != `APMC_PM_FULL_SHUTDOWN && conv_rise) begin
                    state_next = ST_ON;
                end else begin
                    state_next = ST_SHDN;
                end
            end
            default: begin
                state_next = ST_ON;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (!resetn) begin
            state_reg         <= ST_ON;
            conv_cnt_reg      <= 8'h00;
            wait_cnt_reg      <= 32'h0000_0000;
            busy_reg          <= 1'b0;
            ref_on_reg        <= 1'b1;
            core_on_reg       <= 1'b1;
            track_reg         <= 1'b0;
            powered_ready_reg <= 1'b1;
            ctrl_reg_out      <= `APMC_CTRL_RESET;
        end else begin
            state_reg    <= state_next;
            ctrl_reg_out <= ctrl_q;
            conv_cnt_reg <= (state_reg == ST_CONV) ? conv_cnt_reg + 8'h01 : 8'h00;
            busy_reg     <= state_next == ST_CONV;
            // Powered only in the on and converting states
            core_on_reg  <= state_next == ST_ON || state_next == ST_CONV;
            ref_on_reg   <= state_next != ST_SHDN;
            // Hold while sleeping or converting; any wake edge restores track
            if (state_next == ST_STBY || state_next == ST_SHDN || state_next == ST_CONV) begin
                track_reg <= 1'b0;
            end else if (conv_rise || state_reg != ST_ON) begin
                track_reg <= 1'b1;
            end
            // Ready flag only; host owns the waits and is not refused
            if (state_reg == ST_STBY && state_next == ST_ON) begin
                wait_cnt_reg      <= STBY_CYC;
                powered_ready_reg <= 1'b0;
            end else if (state_reg == ST_SHDN && state_next == ST_ON) begin
                wait_cnt_reg      <= SHDN_CYC;
                powered_ready_reg <= 1'b0;
            end else if (state_next != ST_ON && state_next != ST_CONV) begin
                powered_ready_reg <= 1'b0;
            end else if (wait_cnt_reg != 32'h0000_0000) begin
                wait_cnt_reg <= wait_cnt_reg - 32'h0000_0001;
            end else begin
                powered_ready_reg <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [apmc_consts.vh]
// Purpose: Constants for the converter power-mode sequencer
// Assumes: core_clk at 250 MHz (4 ns period)
// Notes:   Times kept in their own unit, cycle counts derived from them
`ifndef APMC_CONSTS_VH
`define APMC_CONSTS_VH

`define APMC_CLK_PERIOD_PS      32'd4000
`define APMC_PM_NORMAL          2'b00
`define APMC_PM_AUTO_SHUTDOWN   2'b01
`define APMC_PM_AUTO_STANDBY    2'b10
`define APMC_PM_FULL_SHUTDOWN   2'b11
`define APMC_PM_LOW_POS         0
`define APMC_PM_HIGH_POS        1
`define APMC_PM_RESET           2'b00
`define APMC_CTRL_RESET         12'h000
`define APMC_CONV_CYCLES        8'd13
`define APMC_STBY_EXT_NS        600
`define APMC_STBY_INT_NS        7000
`define APMC_SHDN_MS            10
`define APMC_STBY_EXT_CYC       ((`APMC_STBY_EXT_NS * 1000 + 3999) / 4000)
`define APMC_STBY_INT_CYC       ((`APMC_STBY_INT_NS * 1000 + 3999) / 4000)
`define APMC_SHDN_CYC           (`APMC_SHDN_MS * (1000000000 / 4000))

`endif

// [apmc_ctrl_mem.v]
// Purpose: Control register storage of the converter
// Assumes: Synchronous active-low reset, single write port
// Notes:   Read data comes out of a register
`timescale 1ns/1ps
`default_nettype none
`include "apmc_consts.vh"

module apmc_ctrl_mem #(
    parameter WIDTH = 12
) (
    // Clock and reset
    input  wire             core_clk,
    input  wire             resetn,
    // Write side
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    // Read side
    output reg  [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] store_reg;

    always @(posedge core_clk) begin
        if (!resetn) begin
            store_reg <= `APMC_CTRL_RESET;
            rd_data   <= `APMC_CTRL_RESET;
        end else begin
            // Contents held in every mode, only a write alters them
            if (wr_en) begin
                store_reg <= wr_data;
            end
            rd_data <= wr_en ? wr_data : store_reg;
        end
    end

endmodule
`default_nettype wire

// [apmc_checker.sv]
// Purpose: Port assertions for the power-mode sequencer
// Assumes: One clock, synchronous active-low reset
// Notes:   Windows of 0 to 3 edges absorb the two-edge answer
`timescale 1ns/1ps
`default_nettype none
module apmc_checker #(parameter int CTRL_WIDTH = 12) (
    // Clock, reset and host side
    input wire logic                  core_clk,
    input wire logic                  resetn,
    input wire logic                  cs_n,
    input wire logic                  wr_n,
    input wire logic [CTRL_WIDTH-1:0] wr_data,
    input wire logic                  start_convert_n,
    // Status
    input wire logic                  busy_reg,
    input wire logic                  ref_on_reg,
    input wire logic                  core_on_reg,
    input wire logic                  track_reg,
    input wire logic [CTRL_WIDTH-1:0] ctrl_reg_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_reset_normal: assert property (disable iff (1'h0) !resetn
        |=> ctrl_reg_out == '0 && core_on_reg && ref_on_reg && !busy_reg) else $error("bad reset");
    a_shdn_write: assert property ($rose(wr_n) && !cs_n && wr_data[1:0] == 2'h3
        |-> ##[1:3] !core_on_reg && !ref_on_reg && !track_reg) else $error("no shutdown");
    a_shdn_stays: assert property (cs_n[*4] ##0 (!core_on_reg && ctrl_reg_out[1:0] == 2'h3)
        |=> !core_on_reg && !track_reg && $stable(ctrl_reg_out)) else $error("left shutdown");
    a_ctrl_write: assert property ($rose(wr_n) && !cs_n
        |-> ##[1:3] ctrl_reg_out == $past(wr_data)) else $error("write not stored");
    a_busy_span: assert property ($rose(busy_reg)
        |-> busy_reg[*8] ##1 busy_reg[*5] ##[1:2] !busy_reg) else $error("busy length");
    a_stby_down: assert property ($fell(busy_reg) && ctrl_reg_out[1:0] == 2'h2
        |-> ##[0:2] !core_on_reg && ref_on_reg && !track_reg) else $error("no standby");
    a_ashdn_down: assert property ($fell(busy_reg) && ctrl_reg_out[1:0] == 2'h1
        |-> ##[0:2] !core_on_reg && !ref_on_reg && !track_reg) else $error("no autoshutdown");
    a_auto_wake: assert property (!core_on_reg && ctrl_reg_out[0] != ctrl_reg_out[1]
        && $rose(start_convert_n) |-> ##[1:3] core_on_reg && track_reg) else $error("no wake");
    c_stby_sleep: cover property ($fell(busy_reg) && ctrl_reg_out[1:0] == 2'h2);
    c_full_shdn: cover property (ctrl_reg_out[1:0] == 2'h3 && !core_on_reg);
    c_auto_wake: cover property (!core_on_reg ##1 core_on_reg);
endmodule
`default_nettype wire

// [apmc_host_model.sv]
// Purpose: Host processor model on the converter bus
// Assumes: Requests change one ns after a rising edge
// Notes:   Data bus scrambled once the write hold has passed
`timescale 1ns/1ps
`default_nettype none
module apmc_host_model (
    // Clock and status
    input  wire logic        core_clk,
    input  wire logic        busy_reg,
    // Bus and start line
    output var  logic        cs_n,
    output var  logic        wr_n,
    output var  logic [11:0] wr_data,
    output var  logic        start_convert_n
);
    initial {cs_n, wr_n, start_convert_n, wr_data} = {3'h7, 12'h000};
    task automatic write_word(input logic [11:0] d);
        @(posedge core_clk);
        #1 {cs_n, wr_n, wr_data} = {2'h0, d};
        @(posedge core_clk);
        #1 wr_n = 1'h1;
        repeat (3) @(posedge core_clk);
        #1 {cs_n, wr_data} = {1'h1, ~d};
    endtask
    // Busy fall used as the completion event
    task automatic convert(output logic seen);
        @(posedge core_clk);
        #1 start_convert_n = 1'h0;
        repeat (4) @(posedge core_clk);
        #1 seen = busy_reg;
        for (int n = 0; n < 40 && busy_reg === 1'h1; n++) #4;
    endtask
    task automatic wake(input int wait_cyc);
        @(posedge core_clk);
        #1 start_convert_n = 1'h1;
        repeat (wait_cyc) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// [tb_apmc_power_ctrl.sv]
// Purpose: Self-checking bench for the power-mode sequencer
// Assumes: External reference, shutdown wait cut to 100 cycles
// Notes:   Waits padded by a few edges for the registered answer
`timescale 1ns/1ps
`default_nettype none
`include "apmc_consts.vh"
module tb_apmc_power_ctrl;
    logic        core_clk = 1'h0;
    logic        resetn = 1'h0;
    logic        cs_n, wr_n, start_convert_n, busy_reg, ref_on_reg, core_on_reg, track_reg;
    logic        powered_ready_reg, seen;
    logic [11:0] wr_data, ctrl_reg_out;
    int          n_mismatch = 0;
    int          total_checks = 0;
    always #2 core_clk = ~core_clk;
    apmc_power_ctrl #(.SHDN_CYC(100), .INT_REF(0)) u_apmc_power_ctrl (
        .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n), .wr_data(wr_data),
        .start_convert_n(start_convert_n), .busy_reg(busy_reg), .ref_on_reg(ref_on_reg),
        .core_on_reg(core_on_reg), .track_reg(track_reg),
        .powered_ready_reg(powered_ready_reg), .ctrl_reg_out(ctrl_reg_out));
    apmc_host_model u_apmc_host_model (.core_clk(core_clk), .busy_reg(busy_reg), .cs_n(cs_n),
        .wr_n(wr_n), .wr_data(wr_data), .start_convert_n(start_convert_n));
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic see(input logic [3:0] exp);
        repeat (3) @(posedge core_clk);
        #1 check("busy ref core track", {8'h00, exp},
            {8'h00, busy_reg, ref_on_reg, core_on_reg, track_reg});
    endtask
    task automatic ready(input int cyc);
        repeat (cyc - 8) @(posedge core_clk);
        #1 check("ready low", 12'h000, {11'h000, powered_ready_reg});
        repeat (16) @(posedge core_clk);
        #1 check("ready", 12'h001, {11'h000, powered_ready_reg});
    endtask
    task automatic t_normal;
        see(4'h6);
        check("control", 12'h000, ctrl_reg_out);
        u_apmc_host_model.convert(seen);
        check("busy seen", 12'h001, {11'h000, seen});
        u_apmc_host_model.wake(0);
        see(4'h7);
        $display("normal test done");
    endtask
    task automatic t_auto(input logic [11:0] word, input logic [3:0] asleep, input int cyc);
        u_apmc_host_model.write_word(word);
        u_apmc_host_model.convert(seen);
        see(asleep);
        u_apmc_host_model.wake(0);
        see(4'h7);
        ready(cyc);
        $display("auto mode test done");
    endtask
    task automatic t_full;
        u_apmc_host_model.write_word(12'h0A3);
        see(4'h0);
        check("control", 12'h0A3, ctrl_reg_out);
        u_apmc_host_model.convert(seen);
        u_apmc_host_model.wake(0);
        check("busy seen", 12'h000, {11'h000, seen});
        see(4'h0);
        u_apmc_host_model.write_word(12'h0A0);
        see(4'h7);
        ready(100);
        $display("full shutdown test done");
    endtask
    task automatic t_reset;
        u_apmc_host_model.write_word(12'h0A3);
        see(4'h0);
        u_apmc_host_model.write_word(12'h0A2);
        see(4'h4);
        @(posedge core_clk);
        #1 resetn = 1'h0;
        repeat (2) @(posedge core_clk);
        #1 resetn = 1'h1;
        see(4'h6);
        check("control", 12'h000, ctrl_reg_out);
        check("ready", 12'h001, {11'h000, powered_ready_reg});
        $display("reset test done");
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 resetn = 1'h1;
        t_normal();
        t_auto(12'h002, 4'h4, `APMC_STBY_EXT_CYC);
        t_auto(12'h001, 4'h0, 100);
        t_full();
        t_reset();
        final_report();
    end
    // Whole run needs well under a thousand edges
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        final_report();
    end
endmodule
bind apmc_power_ctrl apmc_checker #(.CTRL_WIDTH(CTRL_WIDTH)) u_apmc_checker (
    .core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n), .wr_data(wr_data),
    .start_convert_n(start_convert_n), .busy_reg(busy_reg), .ref_on_reg(ref_on_reg),
    .core_on_reg(core_on_reg), .track_reg(track_reg), .ctrl_reg_out(ctrl_reg_out));
`default_nettype wire
